// ### rtl/process_alarm_evaluator.sv
/*
  Two setpoint alarm channels with APB registers and one interrupt.
  Assumes all measurement inputs are synchronous to clk, signed
  16-bit integers in display units, and an APB master on the bus.
*/
// The address map and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// R1: two channels, each fully configurable
// R2: mode holds sense bit and source
// R3: reverse sense opens contact when active
// R4: direct sense closes contact when active
// R5: process value above trip alarms
// R6: outside setpoint plus/minus trip alarms
// R7: deviation side set by trip sign
// R8: loop percent output above trip alarms
// R9: input B or C above trip
// R10: program request alone, trip ignored
// R11: fault or program request, trip ignored
// R12: calculated value 0-3 above trip
// R13: any alarm word bit alarms
// R14: trip clamped to -999 through 9999
// R15: turn-on delay 0 to 250 s
// R16: turn-off delay 0 to 250 s
// R17: broken delay restarts from zero
// R18: one-second tick, zero delay immediate
module process_alarm_evaluator #(
  parameter int unsigned TickCycles = alarm_pkg::TICK_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic signed [15:0] loopPv1,
  input  wire logic signed [15:0] loopPv2,
  input  wire logic signed [15:0] loopSp1,
  input  wire logic signed [15:0] loopSp2,
  input  wire logic signed [15:0] loopOut1,
  input  wire logic signed [15:0] loopOut2,
  input  wire logic signed [15:0] inputB,
  input  wire logic signed [15:0] inputC,
  input  wire logic signed [15:0] calcValue0,
  input  wire logic signed [15:0] calcValue1,
  input  wire logic signed [15:0] calcValue2,
  input  wire logic signed [15:0] calcValue3,
  input  wire logic [1:0]         programReq,
  input  wire logic               inputFault,
  input  wire logic [15:0]        alarmWord0,
  input  wire logic [15:0]        alarmWord1,
  output logic [1:0]              contactClosed,
  output logic                    irq
);
  import alarm_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Sign extension so sums never overflow
  function automatic logic signed [17:0] widen(
    input logic signed [15:0] v
  );
    return {{2{v[15]}}, v};
  endfunction : widen

  // Strict greater-than on widened values
  function automatic logic exceeds(
    input logic signed [17:0] value,
    input logic signed [17:0] limit
  );
    return value > limit;
  endfunction : exceeds

  // Word-aligned address inside the map
  function automatic logic mapped(input logic [11:0] addr);
    return (addr[1:0] == 2'b00) && (addr <= IRQ_MASK_OFF);
  endfunction : mapped

  // Clamp a written trip value into its legal range
  function automatic logic signed [15:0] clampTrip(
    input logic [31:0] w
  );
    if ($signed(w) < TRIP_MIN) return 16'(TRIP_MIN);
    if ($signed(w) > TRIP_MAX) return 16'(TRIP_MAX);
    return w[15:0];
  endfunction : clampTrip

  // Clamp a written delay to the longest setting
  function automatic logic [7:0] clampDelay(input logic [31:0] w);
    if (w > {24'h000000, DELAY_MAX}) return DELAY_MAX;
    return w[7:0];
  endfunction : clampDelay

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [8:0]         mode_q    [2];
  logic [8:0]         mode_d    [2];
  logic signed [15:0] trip_q    [2];
  logic signed [15:0] trip_d    [2];
  logic [7:0]         onDly_q   [2];
  logic [7:0]         onDly_d   [2];
  logic [7:0]         offDly_q  [2];
  logic [7:0]         offDly_d  [2];
  logic [3:0]         irqStat_q, irqStat_d;
  logic [3:0]         irqMask_q, irqMask_d;
  logic [31:0]        prdata_q, prdata_d;
  logic               slvErr_q, slvErr_d;
  logic [1:0]         active_q, active_d;
  logic [1:0]         contact_q, contact_d;
  logic [1:0]         cond;
  logic [1:0]         active;
  logic [3:0]         events;
  logic               tick;
  logic               setupPhase;
  logic               writeHit;
  logic               chSel;
  logic [1:0]         regSel;
  logic [5:0]         statusWord;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------

  // Zero-wait slave: every access phase completes at once
  assign pready     = 1'b1;
  assign setupPhase = psel && !penable;
  assign writeHit   = psel && penable && pready && pwrite && mapped(paddr);
  assign chSel      = paddr[CH_SEL_BIT];
  assign regSel     = paddr[REG_SEL_LSB +: 2];
  assign statusWord = {contact_q, active_q, cond};

  // ----------------------------------------------------------------
  // Channel configuration registers
  // ----------------------------------------------------------------

  // R1: per-channel settings
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      mode_d[c]   = mode_q[c];
      trip_d[c]   = trip_q[c];
      onDly_d[c]  = onDly_q[c];
      offDly_d[c] = offDly_q[c];
    end
    if (writeHit && (paddr < STATUS_OFF)) begin
      unique case (regSel)
        // R2: sense bit and source
        2'b00: mode_d[chSel] = {pwdata[MODE_REV_BIT], 3'b000,
                                pwdata[MODE_SRC_W-1:0]};
        // R14: trip clamp
        2'b01: trip_d[chSel] = clampTrip(pwdata);
        // R15: on delay setting
        2'b10: onDly_d[chSel] = clampDelay(pwdata);
        // R16: off delay setting
        2'b11: offDly_d[chSel] = clampDelay(pwdata);
      endcase
    end
  end

  always_ff @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (rst) begin
        mode_q[c]   <= MODE_RESET;
        trip_q[c]   <= TRIP_RESET;
        onDly_q[c]  <= DELAY_RESET;
        offDly_q[c] <= DELAY_RESET;
      end else begin
        mode_q[c]   <= mode_d[c];
        trip_q[c]   <= trip_d[c];
        onDly_q[c]  <= onDly_d[c];
        offDly_q[c] <= offDly_d[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and error response
  // ----------------------------------------------------------------

  // Captured in the setup cycle, held through the access phase
  always_comb begin
    prdata_d = prdata_q;
    slvErr_d = slvErr_q;
    if (setupPhase) begin
      prdata_d = 32'h00000000;
      slvErr_d = !mapped(paddr);
      if (mapped(paddr) && (paddr < STATUS_OFF)) begin
        unique case (regSel)
          2'b00: prdata_d = {23'h0, mode_q[chSel]};
          2'b01: prdata_d = 32'(signed'(trip_q[chSel]));
          2'b10: prdata_d = {24'h000000, onDly_q[chSel]};
          2'b11: prdata_d = {24'h000000, offDly_q[chSel]};
        endcase
      end else if (paddr == STATUS_OFF) begin
        prdata_d = {26'h0, statusWord};
      end else if (paddr == IRQ_STAT_OFF) begin
        prdata_d = {28'h0000000, irqStat_q};
      end else if (paddr == IRQ_MASK_OFF) begin
        prdata_d = {28'h0000000, irqMask_q};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q <= 32'h00000000;
      slvErr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      slvErr_q <= slvErr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = slvErr_q;

  // ----------------------------------------------------------------
  // Alarm condition per channel
  // ----------------------------------------------------------------

  // Compare the selected source against the trip value
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      cond[c] = 1'b0;
      unique case (source_type'(mode_q[c][MODE_SRC_W-1:0]))
        // R5: process value
        LOOP_PROCESS_VALUE_SOURCE_1:
          cond[c] = exceeds(widen(loopPv1), widen(trip_q[c]));
        LOOP_PROCESS_VALUE_SOURCE_2:
          cond[c] = exceeds(widen(loopPv2), widen(trip_q[c]));
        // R6: band both sides
        SETPOINT_BAND_SOURCE_1:
          cond[c] =
            exceeds(widen(loopPv1), widen(loopSp1) + widen(trip_q[c]))
            || exceeds(widen(loopSp1) - widen(trip_q[c]), widen(loopPv1));
        SETPOINT_BAND_SOURCE_2:
          cond[c] =
            exceeds(widen(loopPv2), widen(loopSp2) + widen(trip_q[c]))
            || exceeds(widen(loopSp2) - widen(trip_q[c]), widen(loopPv2));
        // R7: one-sided deviation
        SETPOINT_DEVIATION_SOURCE_1:
          cond[c] = trip_q[c][15]
            ? exceeds(widen(loopSp1) + widen(trip_q[c]), widen(loopPv1))
            : exceeds(widen(loopPv1), widen(loopSp1) + widen(trip_q[c]));
        SETPOINT_DEVIATION_SOURCE_2:
          cond[c] = trip_q[c][15]
            ? exceeds(widen(loopSp2) + widen(trip_q[c]), widen(loopPv2))
            : exceeds(widen(loopPv2), widen(loopSp2) + widen(trip_q[c]));
        // R8: percent output
        LOOP_OUTPUT_PERCENT_SOURCE_1:
          cond[c] = exceeds(widen(loopOut1), widen(trip_q[c]));
        LOOP_OUTPUT_PERCENT_SOURCE_2:
          cond[c] = exceeds(widen(loopOut2), widen(trip_q[c]));
        // R9: analog inputs
        ANALOG_INPUT_B_SOURCE:
          cond[c] = exceeds(widen(inputB), widen(trip_q[c]));
        ANALOG_INPUT_C_SOURCE:
          cond[c] = exceeds(widen(inputC), widen(trip_q[c]));
        // R10: program only
        INTERNAL_PROGRAM_SOURCE:
          cond[c] = programReq[c];
        // R11: fault or program
        INPUT_FAULT_SOURCE:
          cond[c] = inputFault || programReq[c];
        // R12: calculated values
        CALC_VALUE_SOURCE_0:
          cond[c] = exceeds(widen(calcValue0), widen(trip_q[c]));
        CALC_VALUE_SOURCE_1:
          cond[c] = exceeds(widen(calcValue1), widen(trip_q[c]));
        CALC_VALUE_SOURCE_2:
          cond[c] = exceeds(widen(calcValue2), widen(trip_q[c]));
        CALC_VALUE_SOURCE_3:
          cond[c] = exceeds(widen(calcValue3), widen(trip_q[c]));
        // R13: any alarm bit
        ALARM_WORD_SOURCE:
          cond[c] = (|alarmWord0) || (|alarmWord1);
        default:
          cond[c] = 1'b0; // Unused source codes never alarm
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Delay timing
  // ----------------------------------------------------------------

  // R18: shared second tick
  second_tick_gen #(
    .TickCycles (TickCycles)
  ) tickGen (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  // One delay timer per channel
  for (genvar c = 0; c < 2; c++) begin : gChannel
    alarm_delay_timer delayTimer (
      .clk      (clk),
      .rst      (rst),
      .tick     (tick),
      .cond     (cond[c]),
      .onDelay  (onDly_q[c]),
      .offDelay (offDly_q[c]),
      .active   (active[c])
    );
  end

  // ----------------------------------------------------------------
  // Contact drive and events
  // ----------------------------------------------------------------

  // Contact sense and activity edges
  always_comb begin
    active_d = active;
    for (int c = 0; c < 2; c++) begin
      // R3: reverse sense
      // R4: direct sense
      contact_d[c] = active[c] ^ mode_q[c][MODE_REV_BIT];
      events[IRQ_ON_LSB + c]  = active[c] && !active_q[c];
      events[IRQ_OFF_LSB + c] = !active[c] && active_q[c];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      active_q  <= 2'b00;
      contact_q <= 2'b00;
    end else begin
      active_q  <= active_d;
      contact_q <= contact_d;
    end
  end

  assign contactClosed = contact_q;

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------

  // Write-one-to-clear; a new event wins over its clear
  always_comb begin
    irqStat_d = irqStat_q;
    irqMask_d = irqMask_q;
    if (writeHit && (paddr == IRQ_STAT_OFF)) begin
      irqStat_d = irqStat_q & ~pwdata[3:0];
    end
    if (writeHit && (paddr == IRQ_MASK_OFF)) begin
      irqMask_d = pwdata[3:0];
    end
    irqStat_d = irqStat_d | events;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_q <= IRQ_RESET;
      irqMask_q <= IRQ_RESET;
    end else begin
      irqStat_q <= irqStat_d;
      irqMask_q <= irqMask_d;
    end
  end

  // Level interrupt while any enabled event is pending
  assign irq = |(irqStat_q & irqMask_q);

endmodule : process_alarm_evaluator
`default_nettype wire

// ### rtl/alarm_pkg.sv
/*
  Shared constants for the two-channel setpoint alarm evaluator:
  register map, field layout, reset values, source codes, timer
  states and the one-second tick count.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package alarm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] MODE0_OFF    = 12'h000;
  localparam logic [11:0] TRIP0_OFF    = 12'h004;
  localparam logic [11:0] ONDLY0_OFF   = 12'h008;
  localparam logic [11:0] OFFDLY0_OFF  = 12'h00C;
  localparam logic [11:0] CH_STRIDE    = 12'h010;
  localparam logic [11:0] STATUS_OFF   = 12'h020;
  localparam logic [11:0] IRQ_STAT_OFF = 12'h024;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h028;
  localparam int          CH_SEL_BIT   = 4;
  localparam int          REG_SEL_LSB  = 2;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          MODE_SRC_W   = 5;
  localparam int          MODE_REV_BIT = 8;
  localparam logic [8:0]  MODE_RESET   = 9'h000;
  localparam logic [15:0] TRIP_RESET   = 16'h0000;
  localparam logic [7:0]  DELAY_RESET  = 8'h00;
  localparam int          TRIP_MIN     = -999;
  localparam int          TRIP_MAX     = 9999;
  localparam logic [7:0]  DELAY_MAX    = 8'hFA;
  localparam int          STAT_COND    = 0;
  localparam int          STAT_ACTIVE  = 2;
  localparam int          STAT_CONTACT = 4;
  localparam int          IRQ_ON_LSB   = 0;
  localparam int          IRQ_OFF_LSB  = 2;
  localparam logic [3:0]  IRQ_RESET    = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES   = TICK_PERIOD_S * 1000000000 / CLK_PERIOD_NS;
  localparam int TICK_W        = 27;

  // ----------------------------------------------------------------
  // Source codes and timer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    LOOP_PROCESS_VALUE_SOURCE_1  = 5'h00,
    LOOP_PROCESS_VALUE_SOURCE_2  = 5'h01,
    SETPOINT_BAND_SOURCE_1       = 5'h02,
    SETPOINT_BAND_SOURCE_2       = 5'h03,
    SETPOINT_DEVIATION_SOURCE_1  = 5'h04,
    SETPOINT_DEVIATION_SOURCE_2  = 5'h05,
    LOOP_OUTPUT_PERCENT_SOURCE_1 = 5'h06,
    LOOP_OUTPUT_PERCENT_SOURCE_2 = 5'h07,
    ANALOG_INPUT_B_SOURCE        = 5'h08,
    ANALOG_INPUT_C_SOURCE        = 5'h09,
    INTERNAL_PROGRAM_SOURCE      = 5'h0A,
    INPUT_FAULT_SOURCE           = 5'h0B,
    CALC_VALUE_SOURCE_0          = 5'h0C,
    CALC_VALUE_SOURCE_1          = 5'h0D,
    CALC_VALUE_SOURCE_2          = 5'h0E,
    CALC_VALUE_SOURCE_3          = 5'h0F,
    ALARM_WORD_SOURCE            = 5'h10
  } source_type;

  typedef enum logic [1:0] {
    TIMER_IDLE      = 2'b00,
    TIMER_ARMING    = 2'b01,
    TIMER_ACTIVE    = 2'b10,
    TIMER_DISARMING = 2'b11
  } timer_state_type;

endpackage : alarm_pkg

// ### rtl/second_tick_gen.sv
/*
  One-second tick generator: a single-cycle pulse every TickCycles.
  Assumes a free-running system clock and synchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
module second_tick_gen #(
  parameter int unsigned TickCycles = alarm_pkg::TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  import alarm_pkg::*;

  logic [TICK_W-1:0] count_q, count_d;
  logic              tick_q, tick_d;

  // Wrap counter and pulse at the end of each period
  always_comb begin
    tick_d  = 1'b0;
    count_d = TICK_W'(count_q + 1'b1);
    if (count_q == TICK_W'(TickCycles - 1)) begin
      count_d = '0;
      tick_d  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
      tick_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q  <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : second_tick_gen
`default_nettype wire

// ### rtl/alarm_delay_timer.sv
/*
  Turn-on and turn-off delay timer for one alarm channel.
  Assumes tick is a one-cycle pulse once a second.
*/
`timescale 1ns/1ns
`default_nettype none
module alarm_delay_timer (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       cond,
  input  wire logic [7:0] onDelay,
  input  wire logic [7:0] offDelay,
  output logic            active
);
  import alarm_pkg::*;

  timer_state_type state_q, state_d;
  logic [7:0]      count_q, count_d;
  logic [7:0]      countInc;

  assign countInc = 8'(count_q + 8'h01);

  // Next state of the delay sequence
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    unique case (state_q)
      TIMER_IDLE: begin
        if (cond) begin
          count_d = 8'h00;
          // R18: zero delay acts
          state_d = (onDelay == 8'h00) ? TIMER_ACTIVE : TIMER_ARMING;
        end
      end
      TIMER_ARMING: begin
        // R17: restart on drop
        if (!cond) begin
          state_d = TIMER_IDLE;
          count_d = 8'h00;
        end else if (tick) begin
          count_d = countInc;
          // R15: turn-on delay
          if (countInc >= onDelay) state_d = TIMER_ACTIVE;
        end
      end
      TIMER_ACTIVE: begin
        if (!cond) begin
          count_d = 8'h00;
          state_d = (offDelay == 8'h00) ? TIMER_IDLE : TIMER_DISARMING;
        end
      end
      TIMER_DISARMING: begin
        // R17: restart on return
        if (cond) begin
          state_d = TIMER_ACTIVE;
          count_d = 8'h00;
        end else if (tick) begin
          count_d = countInc;
          // R16: turn-off delay
          if (countInc >= offDelay) state_d = TIMER_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= TIMER_IDLE;
      count_q <= 8'h00;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  assign active = (state_q == TIMER_ACTIVE) || (state_q == TIMER_DISARMING);
endmodule : alarm_delay_timer
`default_nettype wire

// ### test/process_source_model.sv
/*
  Model of the process measurements seen by the alarm evaluator.
  Assumes the bench sets each level through setMeas.
*/
`timescale 1ns/1ns
`default_nettype none
module process_source_model (
  input  wire logic          clk,
  output logic signed [15:0] meas [12]
);
  // ----------------------------------------
  // Measurement levels
  // ----------------------------------------
  // All levels start at zero
  initial begin
    foreach (meas[i]) meas[i] = 16'sh0000;
  end

  // Change one level just after a rising edge
  task automatic setMeas(input int idx, input logic signed [15:0] v);
    @(posedge clk);
    meas[idx] <= v;
  endtask : setMeas
endmodule : process_source_model
`default_nettype wire

// ### test/process_alarm_monitor.sv
/*
  Port checker for the alarm evaluator: bus answers and interrupt.
  Assumes it is bound to the top module with the same TickCycles.
*/
`timescale 1ns/1ns
`default_nettype none
module process_alarm_monitor
  import alarm_pkg::*;
#(
  parameter int unsigned TickCycles = 20
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  contactClosed,
  input wire logic        irq
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic setup;
  logic wr;

  // Bus phase decode
  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite;

  a_ready_high: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_bad_addr: assert property (setup && (paddr > IRQ_MASK_OFF
    || paddr[1:0] != 2'b00) |=> pslverr && prdata == 32'h0)
    else $error("bad address not refused");
  a_good_addr: assert property (setup && paddr <= IRQ_MASK_OFF
    && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("mapped address refused");
  a_rdata_holds: assert property (!setup |=> $stable(prdata))
    else $error("read data moved outside setup");
  a_reset_safe: assert property (disable iff (1'b0)
    rst |=> contactClosed == 2'b00 && !irq)
    else $error("contact or irq set by reset");
  a_irq_cause: assert property ($rose(irq) |->
    $changed(contactClosed) || $past(wr && paddr == IRQ_MASK_OFF))
    else $error("irq rose without cause");
  a_clear_drops: assert property (wr && paddr == IRQ_STAT_OFF
    && pwdata[3:0] == 4'hF |=> !irq || $changed(contactClosed))
    else $error("irq stayed after clear");
  a_mask_zero: assert property (wr && paddr == IRQ_MASK_OFF
    && pwdata[3:0] == 4'h0 |=> !irq)
    else $error("irq high with mask zero");
  c_contact: cover property (contactClosed[0] ##1 !contactClosed[0]);
  c_irq: cover property ($rose(irq));
  c_refused: cover property (setup ##1 pslverr);
endmodule : process_alarm_monitor
`default_nettype wire

// ### test/tb.sv
/*
  Bench for the alarm evaluator: APB tasks and alarm scenarios.
  Assumes the package map and a short TickCycles of 20.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import alarm_pkg::*;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  localparam int unsigned Tck = 20;
  logic               clk, rst, psel, penable, pwrite;
  logic               pready, pslverr, irq, inputFault;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [1:0]         contactClosed, programReq;
  logic [15:0]        alarmWord0, alarmWord1;
  logic signed [15:0] meas [12];
  int                 errTotal, checksDone;

  process_source_model i_src (.clk(clk), .meas(meas));
  process_alarm_evaluator #(.TickCycles(Tck)) i_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .loopPv1(meas[0]),
    .loopPv2(meas[1]), .loopSp1(meas[2]), .loopSp2(meas[3]),
    .loopOut1(meas[4]), .loopOut2(meas[5]), .inputB(meas[6]),
    .inputC(meas[7]), .calcValue0(meas[8]), .calcValue1(meas[9]),
    .calcValue2(meas[10]), .calcValue3(meas[11]),
    .programReq(programReq), .inputFault(inputFault),
    .alarmWord0(alarmWord0), .alarmWord1(alarmWord1),
    .contactClosed(contactClosed), .irq(irq));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    if (errTotal == 0 && checksDone > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      errTotal++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'(pready));
      conclude();
    end
  endtask : apb

  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read", e, rd);
  endtask : rdChk
  // Zero-delay contact lands two edges after the input
  task automatic expC(input int ch, input logic v);
    repeat (3) @(posedge clk);
    chk("contact", 32'(v), 32'(contactClosed[ch]));
  endtask : expC
  task automatic pvCase(input logic signed [15:0] v, input logic e);
    i_src.setMeas(0, v);
    expC(0, e);
  endtask : pvCase
  task automatic waitC(input logic v, input int lim);
    int n;
    n = 0;
    while (contactClosed[0] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("contact wait", 32'(v), 32'(contactClosed[0]));
    if (contactClosed[0] !== v) conclude();
  endtask : waitC

  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    programReq = 2'b00;
    inputFault = 1'b0;
    alarmWord0 = 16'h0000;
    alarmWord1 = 16'h0000;
    errTotal = 0;
    checksDone = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdChk(MODE0_OFF, 32'h0);
    rdChk(STATUS_OFF, 32'h0);
    apb(1'b1, MODE0_OFF, 32'hFFFFFFFF);
    rdChk(MODE0_OFF, 32'h11F);
    apb(1'b1, TRIP0_OFF, 32'd20000);
    rdChk(TRIP0_OFF, 32'd9999);
    apb(1'b1, TRIP0_OFF, 32'hFFFFF830);
    rdChk(TRIP0_OFF, 32'hFFFFFC19);
    apb(1'b1, ONDLY0_OFF, 32'd300);
    rdChk(ONDLY0_OFF, 32'hFA);
    apb(1'b1, ONDLY0_OFF, 32'h0);
    rdChk(12'h02C, 32'h0);
    chk("pslverr", 32'h1, 32'(pslverr));
    apb(1'b1, TRIP0_OFF, 32'd100);
    for (int c = 0; c < 16; c++) begin
      if (c < 2 || (c > 5 && c < 10) || c > 11) begin
        apb(1'b1, MODE0_OFF, 32'(c));
        i_src.setMeas(c < 2 ? c : c < 12 ? c - 2 : c - 4, 16'sd101);
        expC(0, 1'b1);
        i_src.setMeas(c < 2 ? c : c < 12 ? c - 2 : c - 4, 16'sd100);
        expC(0, 1'b0);
      end
    end
    apb(1'b1, MODE0_OFF, 32'h2);
    i_src.setMeas(2, 16'sd1000);
    pvCase(16'sd1101, 1'b1);
    pvCase(16'sd900, 1'b0);
    pvCase(16'sd899, 1'b1);
    apb(1'b1, MODE0_OFF, 32'h4);
    pvCase(16'sd1100, 1'b0);
    pvCase(16'sd1101, 1'b1);
    pvCase(16'sd899, 1'b0);
    apb(1'b1, TRIP0_OFF, 32'hFFFFFF9C);
    pvCase(16'sd900, 1'b0);
    pvCase(16'sd899, 1'b1);
    apb(1'b1, MODE0_OFF, 32'hA);
    inputFault <= 1'b1;
    expC(0, 1'b0);
    programReq <= 2'b01;
    expC(0, 1'b1);
    apb(1'b1, MODE0_OFF, 32'hB);
    programReq <= 2'b00;
    expC(0, 1'b1);
    inputFault <= 1'b0;
    expC(0, 1'b0);
    apb(1'b1, IRQ_MASK_OFF, 32'h1);
    apb(1'b1, IRQ_STAT_OFF, 32'hF);
    apb(1'b1, MODE0_OFF, 32'h10);
    alarmWord1 <= 16'h8000;
    expC(0, 1'b1);
    chk("irq", 32'h1, 32'(irq));
    rdChk(IRQ_STAT_OFF, 32'h1);
    apb(1'b1, IRQ_STAT_OFF, 32'h1);
    @(posedge clk);
    chk("irq", 32'h0, 32'(irq));
    apb(1'b1, IRQ_MASK_OFF, 32'h0);
    alarmWord1 <= 16'h0000;
    expC(0, 1'b0);
    apb(1'b1, MODE0_OFF, 32'h110);
    expC(0, 1'b1);
    alarmWord0 <= 16'h0001;
    expC(0, 1'b0);
    apb(1'b1, MODE0_OFF + CH_STRIDE, 32'h101);
    expC(1, 1'b0);
    apb(1'b1, MODE0_OFF, 32'h10);
    alarmWord0 <= 16'h0000;
    apb(1'b1, ONDLY0_OFF, 32'h2);
    apb(1'b1, OFFDLY0_OFF, 32'h2);
    alarmWord0 <= 16'h0001;
    expC(0, 1'b0);
    waitC(1'b1, 45);
    alarmWord0 <= 16'h0000;
    expC(0, 1'b1);
    waitC(1'b0, 45);
    alarmWord0 <= 16'h0001;
    repeat (18) @(posedge clk);
    alarmWord0 <= 16'h0000;
    @(posedge clk);
    alarmWord0 <= 16'h0001;
    repeat (18) @(posedge clk);
    chk("contact", 32'h0, 32'(contactClosed[0]));
    conclude();
  end
endmodule : tb

bind process_alarm_evaluator process_alarm_monitor #(
  .TickCycles(TickCycles)) i_mon (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .contactClosed(contactClosed), .irq(irq));
`default_nettype wire
